// ===== hdl/phase_detector_control.sv
/*
 * Phase detector and charge-pump control register with the decode of its
 * fields and the steering of the pump raise and lower drives.
 * Assumes the serial register interface, on the same clock, presents one
 * decoded word access per strobe and takes read data one cycle later.
 */
// Functional notes
// - Bits 2:0 select phase detector reset path delay; reset value 1.
// - Bit 3 ties both phase detector inputs together for test; resets 0.
// - Bit 4 flips phase detector polarity; 0 is default positive-slope setting.
// - Bit 5 enables raising output, reset 1; forced raise overrides it.
// - Bit 6 enables lowering output, reset 1; forced lower and mid-rail bits override it.
// - Bits 8:7 set cycle-slip guard: off, 6, 14 or 24 ns; reset 0.
// - Bit 9 holds the pump raise output on for test; resets 0.
// - Bit 10 holds the pump lower output on for test; resets 0.
// - Bit 11 forces the pump output to mid-rail for test; resets 0.
// - Bits 14:12 prescaler bias: nominal, +20, +25, +50 percent; reset 0.
// - Bits 16:15 set charge pump op-amp bias; reset value 3.
// - Bits 18:17 gate main counter below 32, 128, 1023, or never; reset 3.
// - Bits 21:20 set divider pulse width, shortest to longest; reset 0.
module phase_detector_control (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register access from the serial interface.
   input wire logic [5:0] reg_addr_i,
   input wire logic [23:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [23:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Phase detector comparison results and the main divide ratio.
   input wire logic ref_early_i,
   input wire logic vco_early_i,
   input wire logic [10:0] divide_ratio_i,
   // Field outputs to the analog and divider logic.
   output logic [2:0] phase_det_reset_delay_select_o,
   output logic phase_det_inputs_shorted_o,
   output logic phase_det_polarity_flip_o,
   output logic [4:0] cycle_slip_guard_ns_o,
   output logic cycle_slip_guard_on_o,
   output logic [5:0] prescaler_bias_pct_o,
   output logic [1:0] pump_opamp_bias_o,
   output logic main_counter_clock_off_o,
   output logic [1:0] divider_pulse_width_o,
   // Charge pump drives.
   output logic charge_pump_raise_o,
   output logic charge_pump_lower_o,
   output logic charge_pump_midrail_o
);
   logic [23:0] ctrl_r;
   logic [23:0] rdata_r;
   logic rvalid_r;
   logic raise_r;
   logic lower_r;
   logic mid_r;
   logic gate_off_r;

   wire logic hit = (reg_addr_i == pd_ctrl_pkg::PHASE_DETECTOR_CONTROL_ADDR);
   wire logic write_hit = reg_write_i && hit;
   wire logic [23:0] rdata_nxt = hit ? ctrl_r : 24'h000000;

   wire logic [1:0] guard_code = ctrl_r[pd_ctrl_pkg::GUARD_MSB:pd_ctrl_pkg::GUARD_LSB];
   wire logic [2:0] bias_code = ctrl_r[pd_ctrl_pkg::PRESCALER_BIAS_LEVEL_MSB:pd_ctrl_pkg::PRESCALER_BIAS_LEVEL_LSB];
   wire logic [1:0] gate_code = ctrl_r[pd_ctrl_pkg::GATING_MSB:pd_ctrl_pkg::GATING_LSB];
   wire logic shorted = ctrl_r[pd_ctrl_pkg::SHORT_BIT];
   wire logic flip = ctrl_r[pd_ctrl_pkg::FLIP_BIT];
   wire logic raise_en = ctrl_r[pd_ctrl_pkg::RAISE_EN_BIT];
   wire logic lower_en = ctrl_r[pd_ctrl_pkg::LOWER_EN_BIT];
   wire logic force_pump_raise = ctrl_r[pd_ctrl_pkg::FORCE_RAISE_BIT];
   wire logic force_pump_lower = ctrl_r[pd_ctrl_pkg::FORCE_LOWER_BIT];
   wire logic force_pump_midrail = ctrl_r[pd_ctrl_pkg::FORCE_MID_BIT];

   // Shorted inputs see the reference on both sides, so neither leads.
   wire logic ref_lead = ref_early_i && !(shorted || vco_early_i);
   wire logic vco_lead = vco_early_i && !(shorted || ref_early_i);
   // A flipped detector lowers where it would raise.
   wire logic raw_raise = flip ? vco_lead : ref_lead;
   wire logic raw_lower = flip ? ref_lead : vco_lead;
   // Mid-rail wins over both forced drives; a forced drive wins over its enable.
   wire logic raise_nxt = !force_pump_midrail && (force_pump_raise || (raise_en && raw_raise));
   wire logic lower_nxt = !force_pump_midrail && (force_pump_lower || (lower_en && raw_lower));

   wire logic [10:0] gate_limit = gate_limit_of(gate_code);
   wire logic gate_off_nxt = (gate_code != pd_ctrl_pkg::GATE_ALL_ON) && (divide_ratio_i < gate_limit);

   function automatic logic [10:0] gate_limit_of(input logic [1:0] code);
      case (code)
         2'h0: gate_limit_of = pd_ctrl_pkg::GATE_LIMIT_0;
         2'h1: gate_limit_of = pd_ctrl_pkg::GATE_LIMIT_1;
         2'h2: gate_limit_of = pd_ctrl_pkg::GATE_LIMIT_2;
         default: gate_limit_of = 11'h000;
      endcase
   endfunction

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ctrl_r <= pd_ctrl_pkg::PHASE_DETECTOR_CONTROL_RESET;
      end else if (write_hit) begin
         ctrl_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rdata_r <= 24'h000000;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_read_i;
         if (reg_read_i) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         raise_r <= 1'b0;
         lower_r <= 1'b0;
         mid_r <= 1'b0;
         gate_off_r <= 1'b0;
      end else begin
         raise_r <= raise_nxt;
         lower_r <= lower_nxt;
         mid_r <= force_pump_midrail;
         gate_off_r <= gate_off_nxt;
      end
   end

   always_comb begin
      case (guard_code)
         2'h1: cycle_slip_guard_ns_o = pd_ctrl_pkg::GUARD_NS_1;
         2'h2: cycle_slip_guard_ns_o = pd_ctrl_pkg::GUARD_NS_2;
         2'h3: cycle_slip_guard_ns_o = pd_ctrl_pkg::GUARD_NS_3;
         default: cycle_slip_guard_ns_o = pd_ctrl_pkg::GUARD_NS_OFF;
      endcase
   end

   always_comb begin
      case (bias_code)
         3'h1: prescaler_bias_pct_o = pd_ctrl_pkg::PRESCALER_BIAS_LEVEL_PCT_1;
         3'h2: prescaler_bias_pct_o = pd_ctrl_pkg::PRESCALER_BIAS_LEVEL_PCT_2;
         3'h3: prescaler_bias_pct_o = pd_ctrl_pkg::PRESCALER_BIAS_LEVEL_PCT_3;
         default: prescaler_bias_pct_o = pd_ctrl_pkg::PRESCALER_BIAS_LEVEL_PCT_0;
      endcase
   end

   assign cycle_slip_guard_on_o = (guard_code != 2'h0);
   assign phase_det_reset_delay_select_o = ctrl_r[pd_ctrl_pkg::DELAY_MSB:pd_ctrl_pkg::DELAY_LSB];
   assign phase_det_inputs_shorted_o = shorted;
   assign phase_det_polarity_flip_o = flip;
   assign pump_opamp_bias_o = ctrl_r[pd_ctrl_pkg::OPAMP_MSB:pd_ctrl_pkg::OPAMP_LSB];
   assign divider_pulse_width_o = ctrl_r[pd_ctrl_pkg::WIDTH_MSB:pd_ctrl_pkg::WIDTH_LSB];
   assign main_counter_clock_off_o = gate_off_r;
   assign charge_pump_raise_o = raise_r;
   assign charge_pump_lower_o = lower_r;
   assign charge_pump_midrail_o = mid_r;
   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;
endmodule

// ===== inc/pd_ctrl_pkg.sv
/*
 * Constants for the phase detector control register: its address, its field
 * positions, its reset value and the decoded values of its coded fields.
 * Assumes a 24-bit register word and an address space of 64 words.
 */
package pd_ctrl_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam logic [5:0] PHASE_DETECTOR_CONTROL_ADDR = 6'h0B;

   localparam int DELAY_LSB = 0;
   localparam int DELAY_MSB = 2;
   localparam int SHORT_BIT = 3;
   localparam int FLIP_BIT = 4;
   localparam int RAISE_EN_BIT = 5;
   localparam int LOWER_EN_BIT = 6;
   localparam int GUARD_LSB = 7;
   localparam int GUARD_MSB = 8;
   localparam int FORCE_RAISE_BIT = 9;
   localparam int FORCE_LOWER_BIT = 10;
   localparam int FORCE_MID_BIT = 11;
   localparam int PRESCALER_BIAS_LEVEL_LSB = 12;
   localparam int PRESCALER_BIAS_LEVEL_MSB = 14;
   localparam int OPAMP_LSB = 15;
   localparam int OPAMP_MSB = 16;
   localparam int GATING_LSB = 17;
   localparam int GATING_MSB = 18;
   localparam int SPARE_BIT = 19;
   localparam int WIDTH_LSB = 20;
   localparam int WIDTH_MSB = 21;
   localparam int RSVD_LSB = 22;
   localparam int RSVD_MSB = 23;

   localparam logic [23:0] PHASE_DETECTOR_CONTROL_RESET = 24'h0F8061;

   // Cycle-slip guard thresholds in nanoseconds, indexed by code.
   localparam logic [4:0] GUARD_NS_OFF = 5'h00;
   localparam logic [4:0] GUARD_NS_1 = 5'h06;
   localparam logic [4:0] GUARD_NS_2 = 5'h0E;
   localparam logic [4:0] GUARD_NS_3 = 5'h18;

   // Prescaler bias increase in percent, indexed by code.
   localparam logic [5:0] PRESCALER_BIAS_LEVEL_PCT_0 = 6'h00;
   localparam logic [5:0] PRESCALER_BIAS_LEVEL_PCT_1 = 6'h14;
   localparam logic [5:0] PRESCALER_BIAS_LEVEL_PCT_2 = 6'h19;
   localparam logic [5:0] PRESCALER_BIAS_LEVEL_PCT_3 = 6'h32;

   // Divide-ratio limits below which the main counter is gated off.
   localparam logic [10:0] GATE_LIMIT_0 = 11'h020;
   localparam logic [10:0] GATE_LIMIT_1 = 11'h080;
   localparam logic [10:0] GATE_LIMIT_2 = 11'h3FF;
   localparam logic [1:0] GATE_ALL_ON = 2'h3;
endpackage

// ===== verification/pd_host_model.sv
/* Host controller model that issues register writes and reads.
   Assumes the register block samples its strobes on the rising clock edge. */
module pd_host_model #(parameter int CMP_MHZ = 50) (
   input wire logic clk_i,
   output logic [5:0] reg_addr_o,
   output logic [23:0] reg_wdata_o,
   output logic reg_write_o,
   output logic reg_read_o,
   input wire logic [23:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr_o = 6'h00;
      reg_wdata_o = 24'h000000;
      reg_write_o = 1'h0;
      reg_read_o = 1'h0;
   end
   // A released bus shows the inverse of its last value.
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      reg_addr_o <= a;
      reg_wdata_o <= {2'h0, d[21:20], 1'h1, d[18:9], CMP_MHZ <= 50 ? d[8:7] : 2'h0, d[6:0]};
      reg_write_o <= 1'h1;
      @(posedge clk_i) #1;
      reg_write_o <= 1'h0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~reg_wdata_o;
      @(posedge clk_i) #1;
   endtask
   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
      reg_addr_o <= a;
      reg_read_o <= 1'h1;
      @(posedge clk_i) #1;
      reg_read_o <= 1'h0;
      reg_addr_o <= ~a;
      v = reg_rvalid_i;
      d = reg_rdata_i;
      @(posedge clk_i) #1;
   endtask
endmodule

// ===== verification/phase_detector_control_props.sv
/* Checker for the phase detector control register ports.
   Assumes one clock domain with a synchronous active-low reset. */
module phase_detector_control_props (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] reg_addr_i,
   input wire logic [23:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic reg_rvalid_o,
   input wire logic [2:0] phase_det_reset_delay_select_o,
   input wire logic phase_det_polarity_flip_o,
   input wire logic cycle_slip_guard_on_o,
   input wire logic main_counter_clock_off_o,
   input wire logic charge_pump_raise_o,
   input wire logic charge_pump_lower_o,
   input wire logic charge_pump_midrail_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   wire hit = reg_write_i && reg_addr_i == 6'h0B;
   property p_rvalid; reg_read_i |=> reg_rvalid_o; endproperty
   property p_rvalid_once; !reg_read_i |=> !reg_rvalid_o; endproperty
   property p_delay; hit |=> phase_det_reset_delay_select_o == $past(reg_wdata_i[2:0]); endproperty
   property p_flip; hit |=> phase_det_polarity_flip_o == $past(reg_wdata_i[4]); endproperty
   property p_guard; hit |=> cycle_slip_guard_on_o == (|$past(reg_wdata_i[8:7])); endproperty
   property p_force; hit && reg_wdata_i[9] && !reg_wdata_i[11] ##1 !reg_write_i |=> charge_pump_raise_o; endproperty
   property p_short;
      hit && reg_wdata_i[3] && !reg_wdata_i[9] && !reg_wdata_i[11] ##1 !reg_write_i |=> !charge_pump_raise_o;
   endproperty
   property p_force_lower;
      hit && reg_wdata_i[10] && !reg_wdata_i[11] ##1 !reg_write_i |=> charge_pump_lower_o;
   endproperty
   property p_mid; charge_pump_midrail_o |-> !charge_pump_raise_o && !charge_pump_lower_o; endproperty
   property p_gate; hit && reg_wdata_i[18:17] == 2'h3 ##1 !reg_write_i |=> !main_counter_clock_off_o; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   a_rvalid_once: assert property (p_rvalid_once) else $error("stray read valid");
   a_delay: assert property (p_delay) else $error("delay field wrong");
   a_flip: assert property (p_flip) else $error("polarity field wrong");
   a_guard: assert property (p_guard) else $error("guard enable wrong");
   a_force: assert property (p_force) else $error("forced raise missing");
   a_force_lower: assert property (p_force_lower) else $error("forced lower missing");
   a_short: assert property (p_short) else $error("shorted inputs drove pump");
   a_mid: assert property (p_mid) else $error("midrail with drive");
   a_gate: assert property (p_gate) else $error("counter gated with all clocks on");
   c_read: cover property (reg_rvalid_o);
   c_both: cover property (charge_pump_raise_o && charge_pump_lower_o);
   c_mid: cover property (charge_pump_midrail_o);
endmodule
bind phase_detector_control phase_detector_control_props u_props (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
   .reg_write_i, .reg_read_i, .reg_rvalid_o, .phase_det_reset_delay_select_o, .phase_det_polarity_flip_o,
   .cycle_slip_guard_on_o, .main_counter_clock_off_o, .charge_pump_raise_o, .charge_pump_lower_o,
   .charge_pump_midrail_o);

// ===== verification/tb_phase_detector_control.sv
/* Self-checking bench for the phase detector control register.
   Assumes all register traffic comes from the host model. */
module tb_phase_detector_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'h0, resetn_i = 1'h0, ref_early_i = 1'h0, vco_early_i = 1'h0, reg_write_i, reg_read_i;
   logic reg_rvalid_o, phase_det_inputs_shorted_o, phase_det_polarity_flip_o, cycle_slip_guard_on_o;
   logic main_counter_clock_off_o, charge_pump_raise_o, charge_pump_lower_o, charge_pump_midrail_o;
   logic [5:0] reg_addr_i, prescaler_bias_pct_o;
   logic [23:0] reg_wdata_i, reg_rdata_o;
   logic [10:0] divide_ratio_i = 11'h000;
   logic [2:0] phase_det_reset_delay_select_o;
   logic [4:0] cycle_slip_guard_ns_o;
   logic [1:0] pump_opamp_bias_o, main_counter_clock_gating, divider_pulse_width_o;
   int miscompares = 0, n_tests = 0;
   int g[4] = '{0, 6, 14, 24};
   int p[8] = '{0, 20, 25, 50, 0, 0, 0, 0};
   int lim[4] = '{32, 128, 1023, 0};
   always #5 clk_i = ~clk_i;
   pd_host_model u_host (.clk_i, .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_write_o(reg_write_i),
      .reg_read_o(reg_read_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
   phase_detector_control u_dut (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
      .reg_rdata_o, .reg_rvalid_o, .ref_early_i, .vco_early_i, .divide_ratio_i, .phase_det_reset_delay_select_o,
      .phase_det_inputs_shorted_o, .phase_det_polarity_flip_o, .cycle_slip_guard_ns_o, .cycle_slip_guard_on_o,
      .prescaler_bias_pct_o, .pump_opamp_bias_o, .main_counter_clock_off_o, .divider_pulse_width_o,
      .charge_pump_raise_o, .charge_pump_lower_o, .charge_pump_midrail_o);
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      logic [23:0] m, d;
      logic v, r, l, off;
      logic [5:0] a;
      void'($urandom(32'hF0DB3390));
      m = 24'h0F8061;
      repeat (4) @(posedge clk_i);
      #1 resetn_i = 1'h1;
      for (int i = 0; i < 60; i++) begin
         if (i > 0) begin
            m = 24'(($urandom & 32'h003FFFFF) | 32'h00080000);
            u_host.wr(6'h0B, m);
         end
         {ref_early_i, vco_early_i, divide_ratio_i} = 13'($urandom);
         @(posedge clk_i) #1;
         r = !m[11] && (m[9] || m[5] && !m[3] && (m[4] ? vco_early_i && !ref_early_i : ref_early_i && !vco_early_i));
         l = !m[11] && (m[10] || m[6] && !m[3] && (m[4] ? ref_early_i && !vco_early_i : vco_early_i && !ref_early_i));
         off = m[18:17] != 2'h3 && int'(divide_ratio_i) < lim[m[18:17]];
         chk({phase_det_polarity_flip_o, phase_det_inputs_shorted_o, phase_det_reset_delay_select_o,
            pump_opamp_bias_o, divider_pulse_width_o}, {m[4:0], m[16:15], m[21:20]});
         chk({cycle_slip_guard_ns_o, cycle_slip_guard_on_o, prescaler_bias_pct_o},
            {5'(g[m[8:7]]), m[8:7] != 2'h0, 6'(p[m[14:12]])});
         chk({charge_pump_raise_o, charge_pump_lower_o, charge_pump_midrail_o, main_counter_clock_off_o},
            {r, l, m[11], off});
         a = 6'($urandom % 63);
         if (a >= 6'h0B) a++;
         u_host.wr(a, 24'($urandom));
         u_host.rd(6'h0B, d, v);
         chk(d, m);
         chk(v, 1'h1);
         u_host.rd(a, d, v);
         chk(d, 24'h000000);
      end
      give_verdict();
   end
endmodule
